/* hw/eeprom_regs.svh */
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// Word and field widths
`define WORD_BITS 16
`define ADDR_BITS_DEF 6
`define ADDR_BITS_MIN 6
`define ADDR_BITS_MAX 10
`define EXT_MIN_BITS 4

// Clock after the start bit that carries the last address bit of
// a short frame is opcode plus address; data adds one word
`define OPC_FIELD_BITS 2

// Erased cell value
`define ERASED_WORD 16'hFFFF

// Timing: internal program time, longest figure
`define MCLK_PERIOD_NS 20
`define PROG_TIME_NS 4000000
`define PROG_CYCLES_DEF (`PROG_TIME_NS / `MCLK_PERIOD_NS)

`endif

/* hw/eeprom_pkg.sv */
package eeprom_pkg;

   // Two-bit opcode after the start bit
   typedef enum logic [1:0] {
      OPC_EXT = 2'h0,
      OPC_WRITE = 2'h1,
      OPC_READ = 2'h2,
      OPC_ERASE = 2'h3
   } opcode_t;

   // Extended code carried in the two address MSBs
   typedef enum logic [1:0] {
      EXT_PROGRAM_DISABLE_CMD = 2'h0,
      EXT_CHIP_WRITE_ALL = 2'h1,
      EXT_CHIP_ERASE_ALL = 2'h2,
      EXT_PROGRAM_ENABLE_CMD = 2'h3
   } ext_t;

   // Frame state, one-hot
   typedef enum logic [3:0] {
      FR_STBY = 4'h1,
      FR_WAIT = 4'h2,
      FR_SHIFT = 4'h4,
      FR_READ = 4'h8
   } frame_t;

   // Kind of array update in progress
   typedef enum logic [1:0] {
      PG_WORD_WRITE = 2'h0,
      PG_WORD_ERASE = 2'h1,
      PG_CHIP_WRITE = 2'h2,
      PG_CHIP_ERASE = 2'h3
   } prog_t;

   // Serial pins and supply monitor, travel together
   typedef struct packed {
      logic cs;
      logic sck;
      logic sdi;
      logic low;
   } pins_t;

endpackage : eeprom_pkg

/* hw/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   // First stage, read only by the second
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_bad_w
      $error("pin_sync width must be at least one");
   end

   // Two flops before any logic looks at a pin
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         q_out <= '0;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end

endmodule : pin_sync

/* hw/busy_timer.sv */
`timescale 1ns/100ps
module busy_timer #(
   parameter int CYCLES = 200000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // One-cycle start, level busy
   input wire logic start,
   output logic busy_q
);

   localparam int CW = $clog2(CYCLES + 1);

   // Remaining program cycles
   logic [CW-1:0] left_q;

   if (CYCLES < 1) begin : g_bad_cycles
      $error("busy_timer needs at least one cycle");
   end

   // Load on start, count down to zero; busy follows the count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         left_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         left_q <= CW'(CYCLES - 1);
         busy_q <= 1'b1;
      end else if (left_q != '0) begin
         left_q <= left_q - CW'(1);
      end else begin
         busy_q <= 1'b0;
      end
   end

endmodule : busy_timer

/* hw/eeprom_ctrl.sv */
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_ctrl
   import eeprom_pkg::*;
#(
   parameter int AW = `ADDR_BITS_DEF,
   parameter int PROG_CYCLES = `PROG_CYCLES_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Serial bus pins from the host
   input wire logic chip_select,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   // Supply-low or power-on detector
   input wire logic supply_low,
   // Three-state serial output
   output logic serial_data_out,
   output logic serial_data_out_oe,
   // Status levels
   output logic program_enabled,
   output logic program_busy
);

   localparam int WB = `WORD_BITS;
   // Clock counts after the start bit; exact for updates, N_EXT a minimum
   localparam logic [5:0] N_SHORT = 6'(`OPC_FIELD_BITS + AW);
   localparam logic [5:0] N_LONG = 6'(`OPC_FIELD_BITS + AW + WB);
   localparam logic [5:0] N_EXT = 6'(`EXT_MIN_BITS);

   // Width and time checks
   if (AW < `ADDR_BITS_MIN || AW > `ADDR_BITS_MAX) begin : g_bad_aw
      $error("address width must be six to ten");
   end
   if (PROG_CYCLES < (1 << AW)) begin : g_bad_time
      $error("program time shorter than a chip sweep");
   end

   pins_t pin_raw; // Raw pin levels
   pins_t pin_s; // Synchronised pin levels
   logic sk_prev_q; // Last clock level
   logic cs_prev_q; // Last select level
   logic sk_rise; // Rising serial clock
   logic cs_fall; // Select just dropped
   frame_t frame_q; // Frame state
   logic [5:0] cnt_q; // Clocks after start bit, saturating
   logic [WB-1:0] sr_q; // Serial shift register
   opcode_t op_q; // Captured opcode
   ext_t ext_q; // Captured extended code
   logic [AW-1:0] addr_q; // Captured address
   logic enable_q; // Program-enabled state
   logic busy; // Internal program timer running
   logic verify_q; // Verify period pending
   logic wr_class; // Frame is a write-class command
   logic exact; // Clock count matches the command
   prog_t kind_d; // Update kind of this frame
   logic start_prog; // Start an array update
   logic mode_cmd; // Enable or disable takes effect
   prog_t kind_q; // Update kind in progress
   logic [AW-1:0] pa_q; // Update address, sweeps for chip kinds
   logic [WB-1:0] wdata_q; // Word being written
   logic sweep_q; // Array write port active
   logic [WB-1:0] mem_q [(1 << AW)]; // Cell array
   logic [WB-1:0] rd_word_q; // Word being shifted out
   logic [3:0] rd_idx_q; // Bit index within read word
   logic [AW-1:0] rd_addr_q; // Read address, wraps at top
   logic rd_bit_q; // Next read bit for the pin

   assign pin_raw = {chip_select, serial_clock_in, serial_data_in, supply_low};

   // Every pin passes two flops before use
   pin_sync #(.W(4)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d_in(pin_raw),
      .q_out(pin_s)
   );

   // Edge history of the synchronised clock and select
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sk_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end else begin
         sk_prev_q <= pin_s.sck;
         cs_prev_q <= pin_s.cs;
      end
   end

   assign sk_rise = pin_s.sck & ~sk_prev_q;
   assign cs_fall = ~pin_s.cs & cs_prev_q;

   // Frame state; select low always returns to standby
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         frame_q <= FR_STBY;
      end else if (!pin_s.cs) begin
         frame_q <= FR_STBY;
      end else begin
         unique case (frame_q)
            FR_STBY: begin
               frame_q <= FR_WAIT;
            end
            FR_WAIT: begin
               // Dummy clocks with input low are skipped; busy ignores all
               if (sk_rise && pin_s.sdi && !busy) begin
                  frame_q <= FR_SHIFT;
               end
            end
            FR_SHIFT: begin
               // Read leaves shifting after the last address bit
               if (sk_rise && cnt_q == N_SHORT - 6'h01 && op_q == OPC_READ) begin
                  frame_q <= FR_READ;
               end
            end
            FR_READ: begin
               frame_q <= FR_READ;
            end
         endcase
      end
   end

   // Clock counter, shift register and field capture
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 6'h00;
         sr_q <= '0;
         op_q <= OPC_EXT;
         ext_q <= EXT_PROGRAM_DISABLE_CMD;
         addr_q <= '0;
      end else if (frame_q != FR_SHIFT) begin
         cnt_q <= 6'h00;
      end else if (sk_rise) begin
         // Saturate so a runaway frame never wraps back to a legal count
         if (cnt_q != 6'h3F) begin
            cnt_q <= cnt_q + 6'h01;
         end
         sr_q <= {sr_q[WB-2:0], pin_s.sdi};
         if (cnt_q == 6'h01) begin
            op_q <= opcode_t'({sr_q[0], pin_s.sdi});
         end
         if (cnt_q == 6'h03) begin
            ext_q <= ext_t'({sr_q[0], pin_s.sdi});
         end
         if (cnt_q == N_SHORT - 6'h01) begin
            addr_q <= {sr_q[AW-2:0], pin_s.sdi};
         end
      end
   end

   // Decode the finished frame: kind and required count
   always_comb begin
      wr_class = 1'b0;
      exact = 1'b0;
      kind_d = PG_WORD_WRITE;
      unique case (op_q)
         OPC_WRITE: begin
            wr_class = 1'b1;
            exact = (cnt_q == N_LONG);
         end
         OPC_ERASE: begin
            wr_class = 1'b1;
            kind_d = PG_WORD_ERASE;
            exact = (cnt_q == N_SHORT);
         end
         OPC_EXT: begin
            if (ext_q == EXT_CHIP_WRITE_ALL) begin
               wr_class = 1'b1;
               kind_d = PG_CHIP_WRITE;
               exact = (cnt_q == N_LONG);
            end else if (ext_q == EXT_CHIP_ERASE_ALL) begin
               wr_class = 1'b1;
               kind_d = PG_CHIP_ERASE;
               exact = (cnt_q == N_SHORT);
            end
         end
         OPC_READ: begin
            wr_class = 1'b0;
         end
      endcase
   end

   // Updates start only on the select fall, never while held low
   assign start_prog = cs_fall && frame_q == FR_SHIFT && wr_class && exact
      && enable_q && !pin_s.low && !busy;
   // Enable and disable accept the optional address bits
   assign mode_cmd = cs_fall && frame_q == FR_SHIFT && op_q == OPC_EXT
      && cnt_q >= N_EXT && cnt_q <= N_SHORT
      && (ext_q == EXT_PROGRAM_ENABLE_CMD || ext_q == EXT_PROGRAM_DISABLE_CMD);

   // Program-enable state; low supply overrides any command
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= 1'b0;
      end else if (pin_s.low) begin
         enable_q <= 1'b0;
      end else if (mode_cmd) begin
         enable_q <= (ext_q == EXT_PROGRAM_ENABLE_CMD);
      end
   end

   assign program_enabled = enable_q;

   // Program time runs independently of the array sweep
   busy_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .mclk(mclk),
      .reset_n(reset_n),
      .start(start_prog),
      .busy_q(busy)
   );

   assign program_busy = busy;

   // Array update: one cell per cycle; chip kinds sweep every address
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         kind_q <= PG_WORD_WRITE;
         pa_q <= '0;
         wdata_q <= '0;
         sweep_q <= 1'b0;
      end else if (start_prog) begin
         kind_q <= kind_d;
         sweep_q <= 1'b1;
         // Chip kinds ignore the address field
         pa_q <= (kind_d == PG_WORD_WRITE || kind_d == PG_WORD_ERASE) ? addr_q : '0;
         if (kind_d == PG_WORD_ERASE || kind_d == PG_CHIP_ERASE) begin
            wdata_q <= `ERASED_WORD;
         end else begin
            wdata_q <= sr_q;
         end
      end else if (sweep_q) begin
         if (kind_q == PG_WORD_WRITE || kind_q == PG_WORD_ERASE) begin
            sweep_q <= 1'b0;
         end else if (pa_q == {AW{1'b1}}) begin
            sweep_q <= 1'b0;
         end else begin
            pa_q <= pa_q + AW'(1);
         end
      end
   end

   // Cell array write port; no reset, contents are nonvolatile
   always_ff @(posedge mclk) begin
      if (sweep_q) begin
         mem_q[pa_q] <= wdata_q;
      end
   end

   // Verify period: armed by an update, ended by a new start bit
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         verify_q <= 1'b0;
      end else if (start_prog) begin
         verify_q <= 1'b1;
      end else if (frame_q == FR_WAIT && sk_rise && pin_s.sdi && !busy) begin
         verify_q <= 1'b0;
      end
   end

   // Read shifter: low dummy bit, then words with address wrap
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_word_q <= '0;
         rd_idx_q <= 4'h0;
         rd_addr_q <= '0;
         rd_bit_q <= 1'b0;
      end else if (frame_q == FR_SHIFT) begin
         rd_addr_q <= {sr_q[AW-2:0], pin_s.sdi};
         rd_word_q <= mem_q[{sr_q[AW-2:0], pin_s.sdi}];
         rd_idx_q <= 4'h0;
         rd_bit_q <= 1'b0;
      end else if (frame_q == FR_READ && sk_rise) begin
         rd_bit_q <= rd_word_q[WB-1];
         rd_idx_q <= rd_idx_q + 4'h1;
         if (rd_idx_q == 4'hF) begin
            rd_addr_q <= rd_addr_q + AW'(1);
            rd_word_q <= mem_q[rd_addr_q + AW'(1)];
         end else begin
            rd_word_q <= {rd_word_q[WB-2:0], 1'b0};
         end
      end
   end

   // Output driver: floats unless reading or reporting status
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         serial_data_out <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end else if (!pin_s.cs) begin
         serial_data_out_oe <= 1'b0;
      end else if (frame_q == FR_READ) begin
         serial_data_out_oe <= 1'b1;
         serial_data_out <= rd_bit_q;
      end else if (frame_q == FR_WAIT && verify_q) begin
         // Low while busy, high when done
         serial_data_out_oe <= 1'b1;
         serial_data_out <= !busy;
      end else begin
         serial_data_out_oe <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Verify request seen with select still high
   sequence s_verify;
      pin_s.cs && frame_q == FR_WAIT && verify_q;
   endsequence

   // A finished frame whose select just dropped
   sequence s_frame_end;
      cs_fall && frame_q == FR_SHIFT;
   endsequence

   word_erase_ones_a: assert property (
      start_prog && kind_d == PG_WORD_ERASE |=> sweep_q && wdata_q == `ERASED_WORD
         && pa_q == $past(addr_q) ##1 !sweep_q)
      else $error("word erase did not write ones once");
   erase_at_fall_a: assert property (
      start_prog |-> cs_fall && $past(pin_s.cs))
      else $error("update started away from select fall");
   erase_count_a: assert property (
      s_frame_end ##0 (op_q == OPC_ERASE && cnt_q > N_SHORT) |=> !sweep_q)
      else $error("overlong erase frame started an update");
   chip_write_data_a: assert property (
      start_prog && kind_d == PG_CHIP_WRITE |=> sweep_q && pa_q == '0
         && wdata_q == $past(sr_q))
      else $error("chip write did not start at zero with frame data");
   chip_write_count_a: assert property (
      start_prog && kind_d == PG_CHIP_WRITE |-> cnt_q == N_LONG)
      else $error("chip write started with wrong clock count");
   chip_erase_end_a: assert property (
      $fell(sweep_q) && kind_q == PG_CHIP_ERASE |-> $past(pa_q) == {AW{1'b1}}
         && wdata_q == `ERASED_WORD)
      else $error("chip erase ended before the top address");
   chip_erase_count_a: assert property (
      start_prog && kind_d == PG_CHIP_ERASE |-> cnt_q == N_SHORT)
      else $error("chip erase started with wrong clock count");
   enable_cmd_a: assert property (
      mode_cmd && ext_q == EXT_PROGRAM_ENABLE_CMD && !pin_s.low |=> enable_q)
      else $error("enable command not taken");
   disable_cmd_a: assert property (
      mode_cmd && ext_q == EXT_PROGRAM_DISABLE_CMD |=> !enable_q)
      else $error("disable command not taken");
   mode_at_fall_a: assert property (
      $changed(enable_q) |-> $past(mode_cmd || pin_s.low))
      else $error("program mode changed without a command");
   low_supply_a: assert property (
      pin_s.low |=> !enable_q && !$past(start_prog))
      else $error("low supply did not block updates");
   exact_count_a: assert property (
      start_prog |-> (cnt_q == N_LONG && kind_d inside {PG_WORD_WRITE, PG_CHIP_WRITE})
         || (cnt_q == N_SHORT && kind_d inside {PG_WORD_ERASE, PG_CHIP_ERASE}))
      else $error("update started with a mismatched count");
   shift_float_a: assert property (
      frame_q == FR_SHIFT |=> !serial_data_out_oe)
      else $error("output driven while shifting in");
   no_start_low_a: assert property (
      !pin_s.cs && !cs_fall |-> !start_prog)
      else $error("update started with select held low");
   start_bit_a: assert property (
      frame_q == FR_WAIT && pin_s.cs && sk_rise && !pin_s.sdi |=> frame_q == FR_WAIT)
      else $error("dummy clock taken as start bit");
   enabled_only_a: assert property (
      start_prog |-> enable_q)
      else $error("update started while disabled");
   verify_out_a: assert property (
      s_verify |=> serial_data_out_oe && serial_data_out == !$past(busy))
      else $error("verify status wrong");
   standby_a: assert property (
      !pin_s.cs |=> frame_q == FR_STBY && !serial_data_out_oe)
      else $error("not in standby with select low");

endmodule : eeprom_ctrl

/* tb/serial_host.sv */
`timescale 1ns/100ps
module serial_host
   import eeprom_pkg::*;
(
   // Clock that paces the host
   input wire logic mclk,
   // Serial pins to the device
   output logic chip_select,
   output logic serial_clock_in,
   output logic serial_data_in,
   // Answer from the device
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe
);
   // Level the host sees; there is no pull on the line, so a released pin
   // reads as the opposite of its last level and a stale sample shows up
   logic do_line;

   assign do_line = serial_data_out_oe ? serial_data_out : !serial_data_out;

   // Idle: select low, clock still, data low
   initial begin
      chip_select = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
   end

   // Wait n edges, then step just off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tick

   // One 160 ns serial clock; output sampled just before the rise
   task automatic pulse(input logic d, output logic q);
      serial_data_in = d;
      tick(3);
      q = do_line;
      tick(1);
      serial_clock_in = 1'b1;
      tick(4);
      serial_clock_in = 1'b0;
   endtask : pulse

   // Select, dummy zeros, start bit, then n bits from the top; select stays high
   task automatic shift(input logic [31:0] v, input int n, input int dummy);
      logic q;
      chip_select = 1'b1;
      tick(4);
      repeat (dummy) pulse(1'b0, q);
      pulse(1'b1, q);
      for (int i = 0; i < n; i++) pulse(v[31 - i], q);
      // Data low keeps a verify from being taken as a start bit
      serial_data_in = 1'b0;
   endtask : shift

   // Drop select; stay low long enough between frames
   task automatic close();
      chip_select = 1'b0;
      tick(4);
   endtask : close

   // Select again with no start bit and wait for the ready level
   task automatic verify(output logic first, output logic oe, output int cyc);
      chip_select = 1'b1;
      tick(6);
      first = do_line;
      oe = serial_data_out_oe;
      cyc = 0;
      while (do_line !== 1'b1 && cyc < 200) begin
         tick(1);
         cyc++;
      end
      close();
   endtask : verify

   // Read one word; the leading zero comes back separately
   task automatic read_word(input logic [5:0] a, output logic [15:0] w, output logic z);
      logic q;
      shift({OPC_READ, a, 24'h0}, 8, 0);
      pulse(1'b0, z);
      for (int i = 15; i >= 0; i--) begin
         pulse(1'b0, q);
         w[i] = q;
      end
      close();
   endtask : read_word
endmodule : serial_host

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
   import eeprom_pkg::*;
;
   localparam int AW = 6;
   // Program time cut to one sweep of the array
   localparam int PROG = 64;
   // mclk, reset_n and supply_low set at time zero by the main sequence; the serial pins come from the host and the device
   logic mclk;
   logic reset_n;
   logic supply_low;
   logic chip_select, serial_clock_in, serial_data_in;
   logic serial_data_out, serial_data_out_oe, program_enabled, program_busy;
   int bad_count = 0;
   int checked = 0;
   logic [15:0] w;
   logic z;

   // One command and what it should leave behind
   typedef struct {
      logic [31:0] v; // Frame bits after the start bit, from the top
      int n;          // Count of those bits
      logic busy;     // Program time expected to start
      logic en;       // Enable state expected after
      logic [5:0] a;  // Address read back
      logic [15:0] w; // Word expected there
   } row_t;
   row_t rows [11];
   logic [31:0] bad_v [4];
   int bad_n [4];

   // 50 MHz
   always #10 mclk = ~mclk;

   serial_host host (.mclk(mclk), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));

   eeprom_ctrl #(.AW(AW), .PROG_CYCLES(PROG)) dut (.mclk(mclk), .reset_n(reset_n),
      .chip_select(chip_select), .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in), .supply_low(supply_low),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
      .program_enabled(program_enabled), .program_busy(program_busy));

   // Frame bits left-aligned in 32
   function automatic logic [31:0] frm(input opcode_t o, input logic [5:0] a,
                                       input logic [15:0] d);
      return {o, a, d, 8'h0};
   endfunction : frm

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s, seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // Run a command; the mode and busy levels must hold until select falls
   task automatic run_cmd(input logic [31:0] v, input int n, input int dummy, input logic busy);
      logic en0, first, oe;
      int cyc;
      en0 = program_enabled;
      host.shift(v, n, dummy);
      host.tick(8);
      check(program_busy, 1'b0, "busy before select fall");
      check(program_enabled, en0, "mode before select fall");
      host.close();
      host.tick(3);
      check(program_busy, busy, "busy after select fall");
      if (busy) begin
         host.verify(first, oe, cyc);
         check(first, 1'b0, "verify busy level");
         check(oe, 1'b1, "verify drive");
         check(cyc < 200, 1'b1, "ready in time");
      end
   endtask : run_cmd

   // Read a word back and compare
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      host.read_word(a, w, z);
      check(z, 1'b0, "read leading zero");
      check(w, exp, "word read back");
   endtask : rd

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   // Watchdog: the sequence needs well under a millisecond
   initial begin
      #1500000;
      bad_count++;
      give_verdict();
   end

   // Main sequence
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      supply_low = 1'b0;
      rows[0] = '{frm(OPC_EXT, {EXT_CHIP_WRITE_ALL, 4'h9}, 16'h1234), 24, 1, 1, 6'h05, 16'h1234};
      rows[1] = '{frm(OPC_WRITE, 6'h05, 16'hA5A5), 24, 1, 1, 6'h05, 16'hA5A5};
      rows[2] = '{frm(OPC_ERASE, 6'h05, 16'h0), 8, 1, 1, 6'h05, 16'hFFFF};
      rows[3] = '{frm(OPC_EXT, {EXT_PROGRAM_ENABLE_CMD, 4'h0}, 16'h0), 8, 0, 1, 6'h06, 16'h1234};
      rows[4] = '{frm(OPC_EXT, {EXT_CHIP_ERASE_ALL, 4'h5}, 16'h0), 8, 1, 1, 6'h3F, 16'hFFFF};
      rows[5] = '{frm(OPC_EXT, {EXT_CHIP_WRITE_ALL, 4'h0}, 16'h0F0F), 24, 1, 1, 6'h3F, 16'h0F0F};
      rows[6] = '{frm(OPC_EXT, {EXT_PROGRAM_DISABLE_CMD, 4'h0}, 16'h0), 8, 0, 0, 6'h00, 16'h0F0F};
      rows[7] = '{frm(OPC_ERASE, 6'h00, 16'h0), 8, 0, 0, 6'h00, 16'h0F0F};
      rows[8] = '{frm(OPC_EXT, {EXT_CHIP_ERASE_ALL, 4'h0}, 16'h0), 8, 0, 0, 6'h07, 16'h0F0F};
      rows[9] = '{frm(OPC_WRITE, 6'h07, 16'h0), 24, 0, 0, 6'h07, 16'h0F0F};
      rows[10] = '{frm(OPC_EXT, {EXT_CHIP_WRITE_ALL, 4'h0}, 16'h0), 24, 0, 0, 6'h10, 16'h0F0F};
      // Miscounted write-class frames: one extra or one missing clock
      bad_v[0] = frm(OPC_ERASE, 6'h00, 16'h0);
      bad_n[0] = 9;
      bad_v[1] = frm(OPC_EXT, {EXT_CHIP_WRITE_ALL, 4'h0}, 16'h0);
      bad_n[1] = 25;
      bad_v[2] = frm(OPC_EXT, {EXT_CHIP_ERASE_ALL, 4'h0}, 16'h0);
      bad_n[2] = 9;
      bad_v[3] = bad_v[1];
      bad_n[3] = 23;
      host.tick(16);
      reset_n = 1'b1;
      host.tick(1);
      check(program_enabled, 1'b0, "enable after reset");
      check(program_busy, 1'b0, "busy after reset");
      check(serial_data_out_oe, 1'b0, "drive after reset");
      // Power-on habit of the host: disable first, then enable
      run_cmd(rows[6].v, 8, 0, 1'b0);
      check(program_enabled, 1'b0, "disabled at power-on");
      run_cmd(rows[3].v, 8, 0, 1'b0);
      check(program_enabled, 1'b1, "enable command");
      foreach (rows[i]) begin
         run_cmd(rows[i].v, rows[i].n, 0, rows[i].busy);
         check(program_enabled, rows[i].en, "enable state");
         rd(rows[i].a, rows[i].w);
      end
      // Miscounts are cancelled even while enabled
      run_cmd(rows[3].v, 8, 0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         run_cmd(bad_v[i], bad_n[i], 0, 1'b0);
         rd(6'h00, 16'h0F0F);
      end
      // Leading zero clocks before the start bit are ignored
      run_cmd(frm(OPC_ERASE, 6'h2A, 16'h0), 8, 3, 1'b1);
      rd(6'h2A, 16'hFFFF);
      rd(6'h2B, 16'h0F0F);
      // Supply monitor forces disable; recovery needs a fresh enable
      supply_low = 1'b1;
      host.tick(6);
      check(program_enabled, 1'b0, "supply low disables");
      run_cmd(rows[3].v, 8, 0, 1'b0);
      check(program_enabled, 1'b0, "enable refused while low");
      run_cmd(bad_v[0], 8, 0, 1'b0);
      supply_low = 1'b0;
      host.tick(4);
      run_cmd(bad_v[0], 8, 0, 1'b0);
      rd(6'h00, 16'h0F0F);
      run_cmd(rows[3].v, 8, 0, 1'b0);
      run_cmd(bad_v[0], 8, 0, 1'b1);
      rd(6'h00, 16'hFFFF);
      // Clocks with select low are not taken: a disable frame sent in standby
      for (int i = 0; i < 9; i++) host.pulse(i == 0, z);
      host.tick(4);
      check(program_enabled, 1'b1, "standby ignores clocks");
      check(serial_data_out_oe, 1'b0, "standby output floats");
      // Reset in mid-run
      reset_n = 1'b0;
      host.tick(2);
      check(program_enabled, 1'b0, "enable in reset");
      check(serial_data_out_oe, 1'b0, "drive in reset");
      reset_n = 1'b1;
      host.tick(2);
      check(program_busy, 1'b0, "busy after second reset");
      give_verdict();
   end
endmodule : testbench
